// ### decpd_regs.svh
`ifndef DECPD_REGS_SVH
`define DECPD_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define DECPD_IDX_CNT0_LO   10'h2f8
`define DECPD_IDX_CNT0_HI   10'h2f9
`define DECPD_IDX_CNT1_LO   10'h2fa
`define DECPD_IDX_CNT1_HI   10'h2fb
`define DECPD_IDX_CTRL      10'h2fc

// control register field positions
`define DECPD_CTRL_CLR0     0
`define DECPD_CTRL_CLR1     1
`define DECPD_CTRL_RUN      2
`define DECPD_CTRL_MODE     3

// reset values
`define DECPD_CNT_RESET     8'h00
`define DECPD_RUN_RESET     1'b0
`define DECPD_MODE_RESET    1'b0

// timing: system clock, low-speed oscillator and sampling dividers
`define DECPD_CLK_HZ        64'd25000000
`define DECPD_OSC_HZ        64'd32768
`define DECPD_DIV_FAST      64'd16
`define DECPD_DIV_SLOW      64'd128

// system clock cycles per noise rejector sampling period (rounded down)
`define DECPD_SAMPLE_CYCLES(div) ((`DECPD_CLK_HZ * (div)) / `DECPD_OSC_HZ)

`endif

// ### decpd_pkg.sv
package decpd_pkg;

  // noise rejector states, one-hot
  typedef enum logic [3:0]
  {
    DECPD_NR_LOW       = 4'b0001,
    DECPD_NR_RISE_PEND = 4'b0010,
    DECPD_NR_HIGH      = 4'b0100,
    DECPD_NR_FALL_PEND = 4'b1000
  } decpd_nr_state_t;

  // count mode select
  typedef enum logic
  {
    DECPD_MODE_PHASE    = 1'b0,
    DECPD_MODE_SEPARATE = 1'b1
  } decpd_mode_t;

  typedef logic [7:0] decpd_count_t;

endpackage

// ### decpd_noise_rejector.sv
`timescale 1ns/1ps

module decpd_noise_rejector
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sample_tick,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_pulse
);

  import decpd_pkg::*;

  decpd_nr_state_t state_r;
  decpd_nr_state_t state_nxt;
  logic            level_nxt;
  logic            rise_nxt;

  // a new level is passed on only after two agreeing samples one period apart
  always_comb
  begin
    state_nxt = state_r;
    level_nxt = level_out;
    rise_nxt  = 1'b0;
    if (sample_tick)
    begin
      unique case (state_r)
        DECPD_NR_LOW:       state_nxt = pin_in ? DECPD_NR_RISE_PEND : DECPD_NR_LOW;
        DECPD_NR_RISE_PEND:
        begin
          state_nxt = pin_in ? DECPD_NR_HIGH : DECPD_NR_LOW;
          level_nxt = pin_in;
          rise_nxt  = pin_in;
        end
        DECPD_NR_HIGH:      state_nxt = pin_in ? DECPD_NR_HIGH : DECPD_NR_FALL_PEND;
        DECPD_NR_FALL_PEND:
        begin
          state_nxt = pin_in ? DECPD_NR_HIGH : DECPD_NR_LOW;
          level_nxt = pin_in;
        end
        default:            state_nxt = DECPD_NR_LOW;
      endcase
    end
  end

  // state and filtered outputs
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r    <= DECPD_NR_LOW;
      level_out  <= 1'b0;
      rise_pulse <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      level_out  <= level_nxt;
      rise_pulse <= rise_nxt;
    end
  end

  // filtered level moves only on a sampling tick
  level_on_tick_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(level_out) |-> $past(sample_tick))
    else $error("filtered level changed without a sampling tick");

  // a rise needs the pin high at this tick and at the tick before
  rise_stable_a: assert property (@(posedge clk) disable iff (!rstn)
    rise_pulse |-> $past(pin_in) && $past(state_r) == DECPD_NR_RISE_PEND)
    else $error("rise passed without a stable sampling period");

endmodule

// ### decpd_top.sv
// Contract
// - counter zero reads as low nibble at one index, high nibble at next.
// - counter one reads as low nibble at one index, high nibble at next.
// - reset loads both counters with zero.
// - count nibbles are read-only; writes leave counters unchanged.
// - writing one to control bit 0 clears counter zero; zero does nothing.
// - writing one to control bit 1 clears counter one; zero does nothing.
// - both clear bits are write-only and read back as zero.
// - readable run bit 2: one accepts pulses, zero ignores them.
// - pin levels stay readable while counting is stopped.
// - reset clears run and mode bits: stopped, phase-detection mode.
// - mode bit 3: one selects separate mode, zero phase-detection mode.
// - phase mode compares input phases, routes pulses to one counter only.
// - run changes take effect at next falling edge of sampling clock.
// - phase mode: first pin leading advances counter one, second counter zero.
// - separate mode: first pin counts in zero, second pin in one.
// - each counter is an 8-bit binary up counter.
// - inputs pass a noise rejector sampled at oscillator over 16 or 128.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "decpd_regs.svh"

module decpd_top
#(
  parameter int unsigned ADDR_W        = 12,
  parameter bit          SLOW_SAMPLE   = 1'b0,
  parameter int unsigned SAMPLE_CYCLES = int'(SLOW_SAMPLE ?
                                          `DECPD_SAMPLE_CYCLES(`DECPD_DIV_SLOW) :
                                          `DECPD_SAMPLE_CYCLES(`DECPD_DIV_FAST))
)
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              pulse_input_a,
  input  wire logic              pulse_input_b,
  output logic      [1:0]        pin_level,
  output logic                   count_run_active
);

  import decpd_pkg::*;

  localparam int unsigned SCNT_W = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;
  localparam logic [SCNT_W-1:0] SCNT_LAST = SCNT_W'(SAMPLE_CYCLES - 1);

  // register hit: word-aligned byte address equal to four times the index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (addr[1:0] == 2'b00);
  endfunction

  // eight-bit increment with silent wrap
  function automatic decpd_count_t cnt_inc(input decpd_count_t c);
    cnt_inc = c + 8'h01;
  endfunction

  logic [SCNT_W-1:0] samp_cnt_r;
  logic              samp_tick;
  logic              run_r;
  decpd_mode_t       mode_r;
  logic              run_act_r;
  decpd_count_t      cnt0_r;
  decpd_count_t      cnt0_nxt;
  decpd_count_t      cnt1_r;
  decpd_count_t      cnt1_nxt;
  logic              a_lvl;
  logic              a_rise;
  logic              b_lvl;
  logic              b_rise;
  logic              wait_nxt;
  logic [31:0]       rdata_nxt;

  // sampling clock: a falling edge each time the divider wraps
  assign samp_tick = (samp_cnt_r == SCNT_LAST);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      samp_cnt_r <= '0;
    else
      samp_cnt_r <= samp_tick ? '0 : samp_cnt_r + SCNT_W'(1);
  end

  // both pins go through their own rejector
  decpd_noise_rejector u_nr_a
  (
    .clk         (clk),
    .rstn        (rstn),
    .sample_tick (samp_tick),
    .pin_in      (pulse_input_a),
    .level_out   (a_lvl),
    .rise_pulse  (a_rise)
  );

  decpd_noise_rejector u_nr_b
  (
    .clk         (clk),
    .rstn        (rstn),
    .sample_tick (samp_tick),
    .pin_in      (pulse_input_b),
    .level_out   (b_lvl),
    .rise_pulse  (b_rise)
  );

  // bus decode: a write takes effect at the edge where waitrequest is low
  wire wr_take  = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire req_new  = (avs_read | avs_write) & avs_waitrequest;
  wire hit_c0lo = reg_hit(avs_address, `DECPD_IDX_CNT0_LO);
  wire hit_c0hi = reg_hit(avs_address, `DECPD_IDX_CNT0_HI);
  wire hit_c1lo = reg_hit(avs_address, `DECPD_IDX_CNT1_LO);
  wire hit_c1hi = reg_hit(avs_address, `DECPD_IDX_CNT1_HI);
  wire hit_ctrl = reg_hit(avs_address, `DECPD_IDX_CTRL);
  wire ctrl_wr  = wr_take & hit_ctrl;
  wire clr0     = ctrl_wr & avs_writedata[`DECPD_CTRL_CLR0];
  wire clr1     = ctrl_wr & avs_writedata[`DECPD_CTRL_CLR1];

  // pulse routing by mode; a simultaneous rise leads neither way
  wire a_leads  = a_rise & ~b_lvl;
  wire b_leads  = b_rise & ~a_lvl;
  wire sep_mode = (mode_r == DECPD_MODE_SEPARATE);
  wire inc0     = run_act_r & (sep_mode ? a_rise : b_leads);
  wire inc1     = run_act_r & (sep_mode ? b_rise : a_leads);

  // counters: clear wins over a pulse in the same cycle
  assign cnt0_nxt = clr0 ? `DECPD_CNT_RESET : (inc0 ? cnt_inc(cnt0_r) : cnt0_r);
  assign cnt1_nxt = clr1 ? `DECPD_CNT_RESET : (inc1 ? cnt_inc(cnt1_r) : cnt1_r);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt0_r <= `DECPD_CNT_RESET;
      cnt1_r <= `DECPD_CNT_RESET;
    end
    else
    begin
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
    end
  end

  // control bits; nibble indices have no write path
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      run_r  <= `DECPD_RUN_RESET;
      mode_r <= decpd_mode_t'(`DECPD_MODE_RESET);
    end
    else if (ctrl_wr)
    begin
      run_r  <= avs_writedata[`DECPD_CTRL_RUN];
      mode_r <= decpd_mode_t'(avs_writedata[`DECPD_CTRL_MODE]);
    end
  end

  // run reaches the counting path only at a sampling clock falling edge
  always_ff @(posedge clk)
  begin
    if (!rstn)
      run_act_r <= `DECPD_RUN_RESET;
    else if (samp_tick)
      run_act_r <= run_r;
  end

  // read mux: nibbles in the low bits, clear bits read zero, unmapped reads zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_c0lo)
      rdata_nxt[3:0] = cnt0_r[3:0];
    else if (hit_c0hi)
      rdata_nxt[3:0] = cnt0_r[7:4];
    else if (hit_c1lo)
      rdata_nxt[3:0] = cnt1_r[3:0];
    else if (hit_c1hi)
      rdata_nxt[3:0] = cnt1_r[7:4];
    else if (hit_ctrl)
    begin
      rdata_nxt[`DECPD_CTRL_MODE] = mode_r;
      rdata_nxt[`DECPD_CTRL_RUN]  = run_r;
    end
  end

  // one wait cycle per request, then one cycle with waitrequest low
  assign wait_nxt = ~req_new;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= wait_nxt;
      if (avs_read & req_new)
        avs_readdata <= rdata_nxt;
    end
  end

  // pin levels straight from the pins, independent of run
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pin_level        <= 2'b00;
      count_run_active <= 1'b0;
    end
    else
    begin
      pin_level        <= {pulse_input_b, pulse_input_a};
      count_run_active <= run_act_r;
    end
  end

  // reset leaves counters zero and control stopped in phase mode
  reset_state_a: assert property (@(posedge clk)
    $past(!rstn) |-> cnt0_r == 8'h00 && cnt1_r == 8'h00 && !run_r && !mode_r)
    else $error("state not cleared by reset");

  // a clear write zeroes counter zero at the taking edge
  clear_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(clr0) |-> cnt0_r == 8'h00)
    else $error("counter zero not cleared");

  // a zero in the counter-one clear bit leaves it alone
  clear_one_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(ctrl_wr && !avs_writedata[1] && !inc1) |-> $stable(cnt1_r))
    else $error("counter one changed without cause");

  // clear bits always read back as zero
  clear_rd_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !avs_waitrequest && hit_ctrl |-> avs_readdata[1:0] == 2'b00)
    else $error("clear bits read nonzero");

  // counter zero high nibble reads the state at the request's first edge
  nibble_read_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !avs_waitrequest && hit_c0hi |-> avs_readdata == {28'h0, $past(cnt0_r[7:4])})
    else $error("counter zero high nibble read wrong");

  // writes to counter-zero nibbles never move it
  nibble_ro_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(wr_take && (hit_c0lo || hit_c0hi) && !inc0) |-> $stable(cnt0_r))
    else $error("nibble write altered counter zero");

  // while stopped no counter moves except by clear
  stopped_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(!run_act_r && !clr0 && !clr1) |-> $stable(cnt0_r) && $stable(cnt1_r))
    else $error("counter moved while stopped");

  // run takes effect only at a sampling falling edge
  run_sync_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(run_act_r) |-> $past(samp_tick) && run_act_r == $past(run_r))
    else $error("run changed off the sampling edge");

  // phase mode routes a leading first pin to counter one
  phase_route_a: assert property (@(posedge clk) disable iff (!rstn)
    run_act_r && !sep_mode && a_rise && !b_lvl && !clr1 |=> cnt1_r == cnt_inc($past(cnt1_r)))
    else $error("phase mode routing wrong");

  // separate mode counts first pin pulses in counter zero, wrapping silently
  separate_route_a: assert property (@(posedge clk) disable iff (!rstn)
    run_act_r && sep_mode && a_rise && !clr0 |=> cnt0_r == cnt_inc($past(cnt0_r)))
    else $error("separate mode routing wrong");

  // pin levels follow the pins with one cycle of delay
  pin_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    ##1 pin_level == $past({pulse_input_b, pulse_input_a}))
    else $error("pin level readback wrong");

  // a clear write zeroes counter one at the taking edge
  clear_one_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(clr1) |-> cnt1_r == 8'h00)
    else $error("counter one not cleared");

  // a zero in the counter-zero clear bit leaves it alone
  clear_zero_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(ctrl_wr && !avs_writedata[0] && !inc0) |-> $stable(cnt0_r))
    else $error("counter zero changed without cause");

  // counter zero low nibble reads the state at the request's first edge
  cnt0_lo_read_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !avs_waitrequest && hit_c0lo |-> avs_readdata == {28'h0, $past(cnt0_r[3:0])})
    else $error("counter zero low nibble read wrong");

  // counter one low nibble reads the state at the request's first edge
  cnt1_lo_read_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !avs_waitrequest && hit_c1lo |-> avs_readdata == {28'h0, $past(cnt1_r[3:0])})
    else $error("counter one low nibble read wrong");

  // counter one high nibble reads the state at the request's first edge
  cnt1_hi_read_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !avs_waitrequest && hit_c1hi |-> avs_readdata == {28'h0, $past(cnt1_r[7:4])})
    else $error("counter one high nibble read wrong");

  // run and mode read back as held
  ctrl_read_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !avs_waitrequest && hit_ctrl |-> avs_readdata[3:2] == $past({sep_mode, run_r}))
    else $error("control bits read wrong");

  // a control write loads run and mode at the answer edge
  ctrl_take_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(ctrl_wr) |-> {sep_mode, run_r} == $past(avs_writedata[3:2]))
    else $error("control write not taken");

  // writes to counter-one nibbles never move it
  one_nibble_ro_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(wr_take && (hit_c1lo || hit_c1hi) && !inc1) |-> $stable(cnt1_r))
    else $error("nibble write altered counter one");

  // phase mode: a leading first pin leaves counter zero alone
  phase_single_a: assert property (@(posedge clk) disable iff (!rstn)
    run_act_r && !sep_mode && a_rise && !b_lvl && !clr0 |=> $stable(cnt0_r))
    else $error("phase mode advanced both counters");

  // phase mode: a leading second pin advances counter zero
  phase_b_lead_a: assert property (@(posedge clk) disable iff (!rstn)
    run_act_r && !sep_mode && b_rise && !a_lvl && !clr0 |=> cnt0_r == cnt_inc($past(cnt0_r)))
    else $error("phase mode second pin routing wrong");

  // separate mode: second pin pulses advance counter one
  separate_b_a: assert property (@(posedge clk) disable iff (!rstn)
    run_act_r && sep_mode && b_rise && !clr1 |=> cnt1_r == cnt_inc($past(cnt1_r)))
    else $error("separate mode second pin routing wrong");

  // counter zero wraps from all ones to zero
  cnt0_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
    run_act_r && sep_mode && a_rise && !clr0 && cnt0_r == 8'hff |=> cnt0_r == 8'h00)
    else $error("counter zero did not wrap");

  // run seen by the counting path holds between sampling edges
  run_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !samp_tick |=> $stable(run_act_r))
    else $error("run moved between sampling edges");

endmodule

// ### decpd_pulse_src.sv
`timescale 1ns/1ps

module decpd_pulse_src
#(
  parameter int SC = 4
)
(
  input  wire logic clk,
  output logic      pin_a,
  output logic      pin_b
);
  // both sources idle low
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // set both pin levels just after an edge
  task automatic hold(input logic a, input logic b);
    @(posedge clk);
    pin_a <= a;
    pin_b <= b;
  endtask

  // n pulses w ticks wide; kind 0 a only, 1 b only, 2 a leads b, 3 b leads a
  task automatic send(input int n, input int kind, input int w);
    logic fa;
    fa = (kind == 0) || (kind == 2);
    repeat (n)
    begin
      hold(fa, !fa);
      if (kind >= 2)
      begin
        repeat (2 * SC) @(posedge clk);  // lag of two ticks for the trailing pin
        hold(1'b1, 1'b1);
      end
      repeat (w * SC) @(posedge clk);
      if (kind >= 2)
      begin
        hold(!fa, fa);  // leading pin also falls first
        repeat (2 * SC) @(posedge clk);
      end
      hold(1'b0, 1'b0);
      repeat (w * SC) @(posedge clk);
    end
  endtask
endmodule

// ### decpd_test.sv
`timescale 1ns/1ps
`include "decpd_regs.svh"

module decpd_test;
  import decpd_pkg::*;
  localparam int SC = 4;
  logic         clk, rstn, avs_read, avs_write, avs_waitrequest, count_run_active, pa, pb;
  logic [11:0]  avs_address;
  logic [31:0]  avs_writedata, avs_readdata, q;
  logic [3:0]   avs_byteenable;
  logic [1:0]   pin_level;
  int           err_count, checks_done, seed, cyc, n, m, w;
  decpd_count_t e0, e1;

  decpd_top #(.SAMPLE_CYCLES(SC)) dut_u
  (
    .clk              (clk),
    .rstn             (rstn),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_byteenable   (avs_byteenable),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .pulse_input_a    (pa),
    .pulse_input_b    (pb),
    .pin_level        (pin_level),
    .count_run_active (count_run_active)
  );

  decpd_pulse_src #(.SC(SC)) src_u
  (
    .clk   (clk),
    .pin_a (pa),
    .pin_b (pb)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // expected count after n more pulses, wrapping at eight bits
  function automatic decpd_count_t after_n(input decpd_count_t c, input int k);
    return decpd_count_t'(c + k);
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr_en, input logic [9:0] idx, input logic [3:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int k;
    k = 0;
    avs_address    <= {idx, 2'b00};
    avs_read       <= !wr_en;
    avs_write      <= wr_en;
    avs_writedata  <= {28'h0, d};
    avs_byteenable <= be;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 100);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 100)
      chk(32'h0, 32'h1, "bus hang");
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [3:0] d);
    logic [31:0] t;
    bus(1'b1, i, d, 4'hf, t);
  endtask

  task automatic rd(input logic [9:0] i, output logic [31:0] v);
    bus(1'b0, i, 4'h0, 4'hf, v);
  endtask

  // read both nibbles twice until two passes agree
  task automatic rdcnt(input logic [9:0] lo, output decpd_count_t v);
    logic [31:0] a, b, c, d;
    int k;
    k = 0;
    do
    begin
      rd(lo, a);
      rd(lo + 10'h1, b);
      rd(lo, c);
      rd(lo + 10'h1, d);
      k++;
    end
    while ({b[3:0], a[3:0]} !== {d[3:0], c[3:0]} && k < 4);
    v = {b[3:0], a[3:0]};
  endtask

  // compare both counters with the expected values
  task automatic cmp2(input string what);
    decpd_count_t v0, v1;
    rdcnt(`DECPD_IDX_CNT0_LO, v0);
    chk(32'(v0), 32'(e0), what);
    rdcnt(`DECPD_IDX_CNT1_LO, v1);
    chk(32'(v1), 32'(e1), what);
    $display("test %s done", what);
  endtask

  // wait a bounded time for the counting path to follow the run bit
  task automatic wait_run(input logic v);
    int k;
    k = 0;
    while (count_run_active !== v && k < 2 * SC + 4)
    begin
      @(posedge clk);
      k++;
    end
    chk(32'(count_run_active), 32'(v), "run follow");
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      summarize;
    end
  end

  // main sequence
  initial
  begin
    seed = 32'h34c9;
    rstn = 1'b0;
    avs_address = 12'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    e0 = 8'h00;
    e1 = 8'h00;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp2("reset");
    rd(`DECPD_IDX_CTRL, q);
    chk(q, 32'h0, "ctrl reset");
    rd(10'h2fd, q);
    chk(q, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++)
      wr(`DECPD_IDX_CNT0_LO + 10'(i), 4'($random(seed)));
    cmp2("nibble write");
    // pins stay visible while stopped
    src_u.hold(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chk(32'(pin_level), 32'h1, "pin a");
    src_u.hold(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    chk(32'(pin_level), 32'h2, "pin b");
    src_u.send(3, 0, 3);
    cmp2("stopped");
    // separate mode with run
    wr(`DECPD_IDX_CTRL, 4'hf);
    rd(`DECPD_IDX_CTRL, q);
    chk(q, 32'hc, "ctrl readback");
    wait_run(1'b1);
    n = 1 + ($unsigned($random(seed)) % 5);
    m = 1 + ($unsigned($random(seed)) % 5);
    w = 3 + ($unsigned($random(seed)) % 3);
    src_u.send(n, 0, w);
    e0 = after_n(e0, n);
    src_u.send(m, 1, 3);
    e1 = after_n(e1, m);
    cmp2("separate");
    // phase-detection mode
    wr(`DECPD_IDX_CTRL, 4'h4);
    src_u.send(n, 2, 4);
    e1 = after_n(e1, n);
    src_u.send(m, 3, w);
    e0 = after_n(e0, m);
    cmp2("phase");
    // single-cycle glitch is rejected
    src_u.hold(1'b1, 1'b0);
    src_u.hold(1'b0, 1'b0);
    repeat (3 * SC) @(posedge clk);
    cmp2("glitch");
    wr(`DECPD_IDX_CTRL, 4'h5);
    e0 = 8'h00;
    cmp2("clear zero");
    wr(`DECPD_IDX_CTRL, 4'h6);
    e1 = 8'h00;
    cmp2("clear one");
    // wrap past all ones
    wr(`DECPD_IDX_CTRL, 4'hc);
    src_u.send(258, 0, 3);
    e0 = after_n(e0, 258);
    cmp2("wrap");
    // stop ignores pulses
    wr(`DECPD_IDX_CTRL, 4'h8);
    wait_run(1'b0);
    src_u.send(2, 0, 3);
    cmp2("stop");
    bus(1'b1, `DECPD_IDX_CTRL, 4'h4, 4'h0, q);
    rd(`DECPD_IDX_CTRL, q);
    chk(q, 32'h8, "byteenable");
    summarize;
  end
endmodule
